// ### design/pwm_rate_multiplier_dac.sv
`timescale 1ns/1ps
// Contract
// R01: Channel value is 6-bit weight plus 4-bit multiplier
// R02: One shared 10-bit counter, per-channel compare logic
// R03: Counter free-runs, one step per clock
// R04: Low counter rollover sets active channel outputs
// R05: Weight match returns output to inactive level
// R06: Polarity bit inverts the channel output
// R07: Low six weight bits hold pulse width
// R08: Weight register top bit reads as one
// R09: Weight register resets to 80h
// R10: Selected cycles get one extra leading clock
// R11: Multiplier bits select 8, 4/12, 2-mod-4, odd cycles
// R12: Several multiplier bits widen the union
// R13: Cycle zero never gets an increment
// R14: Zero weight and multiplier keep output low
// R15: Full scale is high except one clock
// R16: Software may use a channel as static high
// R17: Outputs driven low after reset
// R18: Multiplier register packs two channels, resets zero
// R19: Cycle index from upper counter, widen before rollover
module pwm_rate_multiplier_dac
   import pwm_brm_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   // APB slave
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [DATA_W-1:0] pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [DATA_W-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Channel pins
   output logic      [CH_NUM-1:0] pwmOut
);

   logic [6:0]        weightQ [CH_NUM];
   logic [6:0]        weightD [CH_NUM];
   logic [3:0]        brmQ    [CH_NUM];
   logic [3:0]        brmD    [CH_NUM];
   logic [CNT_W-1:0]  cntQ;
   logic [CNT_W-1:0]  cntD;
   logic              readyQ;
   logic              readyD;
   logic              errQ;
   logic              errD;
   logic [DATA_W-1:0] rdataQ;
   logic [DATA_W-1:0] rdataD;
   logic [9:0]        wordIdx;
   logic              hit;
   logic              setup;
   logic              doWrite;
   logic [DATA_W-1:0] rd;

   // ****************************************
   // Register file and shared counter
   // ****************************************
   always_comb begin
      weightD = weightQ;
      brmD    = brmQ;
      cntD    = cntQ + 10'h001;                           // R02 R03
      wordIdx = paddr[ADDR_W-1:2];
      setup   = psel && !penable;
      readyD  = setup;
      errD    = 1'b0;
      rdataD  = rdataQ;
      doWrite = psel && penable && readyQ && pwrite && !errQ && pstrb[0];
      hit     = 1'b0;
      rd      = '0;
      for (int c = 0; c < CH_NUM; c++) begin
         if (wordIdx == {2'b00, WEIGHT_IDX[c]}) begin
            hit = 1'b1;
            rd  = {24'h0000_00, 1'b1, weightQ[c]};        // R08
            if (doWrite) begin
               weightD[c] = pwdata[POL_BIT:0];            // R06 R07
            end
         end
      end
      for (int p = 0; p < 2; p++) begin
         if (wordIdx == {2'b00, BRM_IDX[p]}) begin
            hit = 1'b1;
            rd  = {24'h0000_00, brmQ[2*p+1], brmQ[2*p]};  // R18
            if (doWrite) begin
               brmD[2*p+1] = pwdata[BRM_HI_LSB+3:BRM_HI_LSB]; // R18
               brmD[2*p]   = pwdata[3:0];                 // R18
            end
         end
      end
      if (wordIdx == {2'b00, STATUS_IDX}) begin
         hit = 1'b1;
         rd  = {22'h00_0000, cntQ};
      end
      if (paddr[1:0] != 2'b00) begin
         hit = 1'b0;
      end
      if (setup) begin
         errD   = !hit;
         rdataD = hit ? rd : '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         for (int c = 0; c < CH_NUM; c++) begin
            weightQ[c] <= WEIGHT_RST[6:0];                // R09
            brmQ[c]    <= BRM_RST;                        // R18
         end
         cntQ   <= CNT_RST;
         readyQ <= 1'b0;
         errQ   <= 1'b0;
         rdataQ <= '0;
      end else begin
         weightQ <= weightD;
         brmQ    <= brmD;
         cntQ    <= cntD;
         readyQ  <= readyD;
         errQ    <= errD;
         rdataQ  <= rdataD;
      end
   end

   assign prdata  = rdataQ;
   assign pready  = readyQ;
   assign pslverr = errQ;

   // ****************************************
   // Channels
   // ****************************************
   for (genvar g = 0; g < CH_NUM; g++) begin : gCh
      pwm_ch_if chIf ();
      assign chIf.cnt    = cntQ;                          // R02
      assign chIf.weight = weightQ[g][5:0];               // R01
      assign chIf.polarity_invert    = weightQ[g][POL_BIT];           // R06
      assign chIf.brm    = brmQ[g];                       // R01
      pwm_brm_channel uCh (
         .sys_clk (sys_clk),
         .rst_n   (rst_n),
         .ch      (chIf.gen)
      );
      assign pwmOut[g] = chIf.level;
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence brmWr;
      psel && !penable && pwrite && pstrb[0] && paddr == {2'b00, BRM_IDX[0], 2'b00}
      ##1 psel && penable && pready;
   endsequence

   chk_cnt_step: assert property (@(posedge sys_clk) disable iff (!rst_n) // R03
      $past(rst_n) |-> cntQ == $past(cntQ) + 10'h001)
      else $error("Shared counter did not advance by one");

   chk_wt_msb: assert property (@(posedge sys_clk) disable iff (!rst_n) // R08
      (psel && !penable && !pwrite && paddr == {2'b00, WEIGHT_IDX[0], 2'b00})
      |=> pready && prdata[RSV_BIT])
      else $error("Weight register top bit not read as one");

   chk_brm_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // R18
      brmWr |=> {brmQ[1], brmQ[0]} == $past(pwdata[7:0]))
      else $error("Multiplier register write not stored");

   chk_out_reset: assert property (@(posedge sys_clk) disable iff (!rst_n) // R17
      $rose(rst_n) |-> pwmOut == '0 && weightQ[0] == WEIGHT_RST[6:0])
      else $error("Outputs or weights wrong after reset");

endmodule

// ### design/pwm_brm_pkg.sv
package pwm_brm_pkg;

   // ****************************************
   // Sizes
   // ****************************************
   localparam int CNT_W   = 10;
   localparam int LOW_W   = 6;
   localparam int BRM_W   = 4;
   localparam int CH_NUM  = 4;
   localparam int ADDR_W  = 12;
   localparam int DATA_W  = 32;

   // ****************************************
   // Register indices (byte address is four times the index)
   // ****************************************
   localparam logic [7:0] WEIGHT_IDX [CH_NUM] = '{8'h74, 8'h76, 8'h77, 8'h79};
   localparam logic [7:0] BRM_IDX    [2]      = '{8'h75, 8'h78};
   localparam logic [7:0] STATUS_IDX          = 8'h7A;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int         RSV_BIT    = 7;
   localparam int         POL_BIT    = 6;
   localparam int         BRM_HI_LSB = 4;
   localparam logic [7:0] WEIGHT_RST = 8'h80;
   localparam logic [3:0] BRM_RST    = 4'h0;
   localparam logic [9:0] CNT_RST    = 10'h000;
   localparam logic [5:0] LOW_MAX    = 6'h3F;

   // ****************************************
   // Added-increment cycle selection
   // ****************************************
   function automatic logic brmSelect(input logic [3:0] brm, input logic [3:0] idx);
      logic sel;
      sel = 1'b0;
      if (brm[0] && idx == 4'h8) begin                   // R11
         sel = 1'b1;
      end
      if (brm[1] && idx[2:0] == 3'h4) begin              // R11
         sel = 1'b1;
      end
      if (brm[2] && idx[1:0] == 2'h2) begin              // R11 R12
         sel = 1'b1;
      end
      if (brm[3] && idx[0]) begin                        // R11 R12
         sel = 1'b1;
      end
      return sel;
   endfunction

endpackage

// ### design/pwm_ch_if.sv
`timescale 1ns/1ps
interface pwm_ch_if;
   logic [9:0] cnt;
   logic [5:0] weight;
   logic       polarity_invert;
   logic [3:0] brm;
   logic       level;

   modport ctl (output cnt, output weight, output polarity_invert, output brm, input level);
   modport gen (input cnt, input weight, input polarity_invert, input brm, output level);
endinterface

// ### design/pwm_brm_channel.sv
`timescale 1ns/1ps
module pwm_brm_channel
   import pwm_brm_pkg::*;
(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // Channel carrier
   pwm_ch_if.gen     ch
);

   logic [5:0] low;
   logic [3:0] idx;
   logic [3:0] nextIdx;
   logic       pulse;
   logic       outD;
   logic       outQ;

   // ****************************************
   // Pulse generation
   // ****************************************
   always_comb begin
      low     = ch.cnt[LOW_W-1:0];                        // R01
      idx     = ch.cnt[CNT_W-1:LOW_W];                    // R19
      nextIdx = idx + 4'h1;                               // R13 R19
      pulse   = (low < ch.weight);                        // R04 R05 R07
      if (low == LOW_MAX && brmSelect(ch.brm, nextIdx)) begin
         pulse = 1'b1;                                    // R10 R19
      end
      outD = pulse ^ ch.polarity_invert;                              // R06
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         outQ <= 1'b0;                                    // R17
      end else begin
         outQ <= outD;
      end
   end

   assign ch.level = outQ;

   // ****************************************
   // Checks
   // ****************************************
   sequence fullAtWrap;
      ch.weight == LOW_MAX && ch.brm == 4'hF && !ch.polarity_invert && ch.cnt == 10'h3FF;
   endsequence

   sequence dipThenHigh;
      !outQ ##1 (outQ || ch.weight != LOW_MAX || ch.brm != 4'hF || ch.polarity_invert);
   endsequence

   chk_roll_set: assert property (@(posedge sys_clk) disable iff (!rst_n) // R04
      (low == 6'h00 && ch.weight != 6'h00) |=> outQ == !$past(ch.polarity_invert))
      else $error("Output not set at counter rollover");

   chk_match_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // R05
      (low == ch.weight && low != LOW_MAX) |=> outQ == $past(ch.polarity_invert))
      else $error("Output not cleared on weight match");

   chk_cycle0_none: assert property (@(posedge sys_clk) disable iff (!rst_n) // R13
      (low == LOW_MAX && idx == 4'hF) |=> outQ == $past(ch.polarity_invert))
      else $error("Increment added before cycle zero");

   chk_brm_odd: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
      (low == LOW_MAX && ch.brm[3] && !idx[0]) |=> outQ == !$past(ch.polarity_invert))
      else $error("Odd cycle increment missing");

   chk_zero_low: assert property (@(posedge sys_clk) disable iff (!rst_n) // R14
      (ch.weight == 6'h00 && ch.brm == 4'h0 && !ch.polarity_invert) |=> !outQ)
      else $error("Zero setting produced a high output");

   chk_full_scale: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
      fullAtWrap |=> dipThenHigh)
      else $error("Full scale output wrong around cycle zero");

endmodule

// ### verif/pwm_filter_model.sv
`timescale 1ns/1ps
// ****************************************
// Filter model: integrates pin high time
// ****************************************
module pwm_filter_model
   import pwm_brm_pkg::*;
(
   // Clock and control
   input  wire logic              sys_clk,
   input  wire logic              clear,
   // Channel pins
   input  wire logic [CH_NUM-1:0] pwmOut,
   // Charge per channel
   output int                     charge [CH_NUM]
);
   // Unknown pin level adds no charge
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < CH_NUM; i++) begin
         charge[i] <= clear ? 0 : charge[i] + int'(pwmOut[i] === 1'b1);
      end
   end
endmodule

// ### verif/pwm_rate_multiplier_dac_tb.sv
`timescale 1ns/1ps
module pwm_rate_multiplier_dac_tb;
   import pwm_brm_pkg::*;
   logic              sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, clear, err;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic [3:0]        pstrb;
   logic [CH_NUM-1:0] pwmOut;
   int                charge [CH_NUM];
   int                errors, compares;

   pwm_rate_multiplier_dac pwm_rate_multiplier_dac_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwmOut(pwmOut));
   pwm_filter_model pwm_filter_model_inst (.sys_clk(sys_clk), .clear(clear),
      .pwmOut(pwmOut), .charge(charge));

   // ****************************************
   // Shared tasks
   // ****************************************
   function automatic logic [ADDR_W-1:0] adr(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] s);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      pstrb <= s;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic print_verdict();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic reset_values();
      check(32'(pwmOut), 32'h0000_0000);
      for (int i = 0; i < CH_NUM; i++) begin
         apb(1'b0, adr(WEIGHT_IDX[i]), 8'h00, 4'h0);
         check(rd, 32'h0000_0080);
      end
      for (int i = 0; i < 2; i++) begin
         apb(1'b0, adr(BRM_IDX[i]), 8'h00, 4'h0);
         check(rd, 32'h0000_0000);
      end
   endtask
   task automatic reg_access();
      logic [31:0] first;
      apb(1'b0, adr(STATUS_IDX), 8'h00, 4'h0);
      first = rd;
      apb(1'b0, adr(STATUS_IDX), 8'h00, 4'h0);
      check((rd - first) & 32'h0000_03FF, 32'h0000_0003);
      apb(1'b1, adr(WEIGHT_IDX[0]), 8'h3F, 4'hF);
      apb(1'b0, adr(WEIGHT_IDX[0]), 8'h00, 4'h0);
      check(rd, 32'h0000_00BF);
      apb(1'b1, adr(WEIGHT_IDX[0]), 8'h00, 4'h0);
      apb(1'b0, adr(WEIGHT_IDX[0]), 8'h00, 4'h0);
      check(rd, 32'h0000_00BF);
      apb(1'b1, 12'h000, 8'h55, 4'hF);
      check(32'(err), 32'h0000_0001);
      apb(1'b0, 12'h000, 8'h00, 4'h0);
      check(rd, 32'h0000_0000);
      apb(1'b1, adr(BRM_IDX[0]), 8'hA5, 4'hF);
      apb(1'b0, adr(BRM_IDX[0]), 8'h00, 4'h0);
      check(rd, 32'h0000_00A5);
   endtask
   task automatic duty_case(input logic [5:0] w, input logic polarity_invert, input logic [3:0] bLo,
                            input logic [3:0] bHi);
      int exp;
      for (int i = 0; i < CH_NUM; i++) begin
         apb(1'b1, adr(WEIGHT_IDX[i]), {1'b0, polarity_invert, w}, 4'hF);
      end
      apb(1'b1, adr(BRM_IDX[0]), {bHi, bLo}, 4'hF);
      apb(1'b1, adr(BRM_IDX[1]), {bHi, bLo}, 4'hF);
      repeat (3) @(posedge sys_clk);
      clear <= 1'b1;
      @(posedge sys_clk);
      clear <= 1'b0;
      repeat (1024) @(posedge sys_clk);
      #1;
      for (int i = 0; i < CH_NUM; i++) begin
         exp = 16 * int'(w) + int'(i[0] ? bHi : bLo);
         exp = polarity_invert ? 1024 - exp : exp;
         check(32'(charge[i]), 32'(exp));
      end
   endtask
   task automatic static_low();
      duty_case(6'h00, 1'b0, 4'h0, 4'h0);
   endtask
   task automatic full_scale();
      duty_case(6'h3F, 1'b0, 4'hF, 4'hF);
   endtask
   task automatic static_high();
      duty_case(6'h00, 1'b1, 4'h0, 4'h0);
   endtask
   task automatic brm_mix();
      duty_case(6'h18, 1'b0, 4'h6, 4'h1);
      duty_case(6'h20, 1'b0, 4'h2, 4'h4);
      duty_case(6'h05, 1'b1, 4'h8, 4'h0);
      duty_case(6'h00, 1'b0, 4'h1, 4'h8);
   endtask
   task automatic mid_reset();
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      reset_values();
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      print_verdict();
   end
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite, clear, paddr, pwdata, pstrb} = '0;
      errors = 0;
      compares = 0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      reset_values();
      reg_access();
      static_low();
      full_scale();
      static_high();
      brm_mix();
      mid_reset();
      print_verdict();
   end
endmodule
